// file: hw/tc_timer.sv
// How it works
// - high byte writes and count/capture high reads go through shared latch
// - count/capture low byte read copies upper byte to latch
// - low byte write loads latch plus byte
// - one latch serves count, compare, capture
// - software keeps shared-latch sequences interrupt free
// - clock select picks tick, zero stops
// - cpu write beats count and clear
// - tick clears, increments or decrements per mode
// - top and bottom indications from count
// - overflow flag per mode, can interrupt
// - matching edge copies count to capture
// - capture flag set with the copy
// - capture flag interrupts, cleared by ack/one
// - capture read low first, latch upper
// - capture writable only in capture-limit modes
// - trigger from pin, or comparator when selected
// - software clears capture flag after source change
// - inputs synchronised, filter adds four cycles
// - no captures in capture-limit modes
// - filter moves after four equal samples
// - filter enable bit, sampled on system clock
// - new capture overwrites unread value
// - port drive value feeds capture path
//
// Decided for this implementation: the APB slave port and the address map.
`timescale 1ns/100ps
`default_nettype none
module tc_timer import tc_pkg::*; (
	input  wire logic       clk_sys,
	input  wire logic       rst_b,
	tc_cpu_if.dev           cpu,
	input  wire logic [7:0] clockTicks,
	input  wire logic       capturePinIn,
	input  wire logic       portDriveEn,
	input  wire logic       portDriveValue,
	input  wire logic       comparatorOutput,
	output logic            timerTick,
	output logic            atTop,
	output logic            atBottom
);
	typedef struct packed {
		logic [15:0] count;
		logic [15:0] capture;
		logic [15:0] compare;
		logic [7:0]  temp;
		logic [7:0]  ctrlA;
		logic [7:0]  ctrlB;
		logic        capSel;
		logic        ovfFlag;
		logic        capFlag;
		logic        ovfEn;
		logic        capEn;
		logic        down;
		logic [7:0]  rdData;
	} tc_timer_state_type;

	tc_timer_state_type q;
	tc_timer_state_type d;
	tc_mode_type        mode;
	logic [15:0]        top;
	logic [2:0]         clkSel;
	logic               capLimit;
	logic               trigger;
	logic               capEdge;
	logic               ovfSet;
	logic               capSet;
	logic               ovfClr;
	logic               capClr;
	logic               flagWr;

	// the port's own drive value wins when the pin is an output,
	// so software can fire a capture by toggling the port
	assign trigger = q.capSel ? comparatorOutput
		: (portDriveEn ? portDriveValue : capturePinIn);

	tc_capture_filter u_filter (
		.clk_sys    (clk_sys),
		.rst_b      (rst_b),
		.rawIn      (trigger),
		.filterEn   (q.ctrlB[CTRLB_FILT]),
		.risingEdge (q.ctrlB[CTRLB_EDGE]),
		.edgeSeen   (capEdge)
	);

	function automatic logic [15:0] tc_top_value(input tc_top_type s, input logic [15:0] cmp,
		input logic [15:0] cap);
		logic [15:0] v;
		v = TOP_MAX;
		unique case (s)
			TS_MAX: v = TOP_MAX;
			TS_8:   v = TOP_8;
			TS_9:   v = TOP_9;
			TS_10:  v = TOP_10;
			TS_CMP: v = cmp;
			TS_CAP: v = cap;
			default: v = TOP_MAX;
		endcase
		return v;
	endfunction : tc_top_value

	always_comb begin
		d = q;
		mode = tc_decode_mode({q.ctrlB[CTRLB_WGM_HI+1:CTRLB_WGM_HI],
			q.ctrlA[CTRLA_WGM_LO+1:CTRLA_WGM_LO]});
		top = tc_top_value(mode.topSel, q.compare, q.capture);
		capLimit = (mode.topSel == TS_CAP);
		clkSel = q.ctrlB[CTRLB_CS+2:CTRLB_CS];
		timerTick = (clkSel != 3'h0) && clockTicks[clkSel];
		atTop = (q.count == top);
		atBottom = (q.count == WORD_RESET);

		// counting sequence
		if (timerTick) begin
			if (mode.dual) begin
				if (!q.down) begin
					if (atTop) begin
						d.down = 1'b1;
						d.count = q.count - 16'h0001;
					end else begin
						d.count = q.count + 16'h0001;
					end
				end else begin
					if (atBottom) begin
						d.down = 1'b0;
						d.count = q.count + 16'h0001;
					end else begin
						d.count = q.count - 16'h0001;
					end
				end
			end else begin
				d.down = 1'b0;
				d.count = atTop ? WORD_RESET : q.count + 16'h0001;
			end
		end

		unique case (mode.ovfPt)
			OV_MAX:    ovfSet = timerTick && (q.count == TOP_MAX);
			OV_TOP:    ovfSet = timerTick && atTop;
			OV_BOTTOM: ovfSet = timerTick && atBottom && q.down;
			default:   ovfSet = 1'b0;
		endcase

		// a capture in a capture-limit mode would destroy the limit
		capSet = capEdge && !capLimit;
		if (capSet) begin
			d.capture = q.count;
		end

		// cpu reads: data answers one cycle later
		if (cpu.ioRd) begin
			unique case (cpu.ioAddr)
				IO_CNT_LO: begin
					d.rdData = q.count[7:0];
					d.temp = q.count[15:8];
				end
				IO_CAP_LO: begin
					d.rdData = q.capture[7:0];
					d.temp = q.capture[15:8];
				end
				IO_CNT_HI, IO_CAP_HI: d.rdData = q.temp;
				IO_CMP_LO: d.rdData = q.compare[7:0];
				IO_CMP_HI: d.rdData = q.compare[15:8];
				IO_CTRL_A: d.rdData = q.ctrlA;
				IO_CTRL_B: d.rdData = q.ctrlB;
				IO_FLAGS:  d.rdData = 8'({q.capFlag, 5'h00} | {7'h00, q.ovfFlag});
				IO_MASK:   d.rdData = 8'({q.capEn, 5'h00} | {7'h00, q.ovfEn});
				IO_COMP:   d.rdData = 8'({q.capSel, 2'h0});
				default:   d.rdData = 8'h00;
			endcase
		end

		// cpu writes come last so they override counting
		flagWr = cpu.ioWr && (cpu.ioAddr == IO_FLAGS);
		if (cpu.ioWr) begin
			unique case (cpu.ioAddr)
				IO_CNT_HI, IO_CAP_HI, IO_CMP_HI: d.temp = cpu.ioWrData;
				IO_CNT_LO: d.count = {q.temp, cpu.ioWrData};
				IO_CAP_LO: begin
					if (capLimit) begin
						d.capture = {q.temp, cpu.ioWrData};
					end
				end
				IO_CMP_LO: d.compare = {q.temp, cpu.ioWrData};
				IO_CTRL_A: d.ctrlA = cpu.ioWrData;
				IO_CTRL_B: d.ctrlB = cpu.ioWrData;
				IO_MASK: begin
					d.ovfEn = cpu.ioWrData[FLAG_OVF];
					d.capEn = cpu.ioWrData[FLAG_CAP];
				end
				IO_COMP: d.capSel = cpu.ioWrData[COMP_CAPSEL];
				default: d.rdData = q.rdData;
			endcase
		end

		// a set in the same cycle as a clear survives
		ovfClr = cpu.ovfAck || (flagWr && cpu.ioWrData[FLAG_OVF]);
		capClr = cpu.capAck || (flagWr && cpu.ioWrData[FLAG_CAP]);
		d.ovfFlag = ovfSet || (q.ovfFlag && !ovfClr);
		d.capFlag = capSet || (q.capFlag && !capClr);
	end

	assign cpu.ioRdData = q.rdData;
	assign cpu.ovfIrq = q.ovfFlag && q.ovfEn;
	assign cpu.capIrq = q.capFlag && q.capEn;

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			q.count   <= WORD_RESET;
			q.capture <= WORD_RESET;
			q.compare <= WORD_RESET;
			q.temp    <= CTRL_RESET;
			q.ctrlA   <= CTRL_RESET;
			q.ctrlB   <= CTRL_RESET;
			q.capSel  <= 1'b0;
			q.ovfFlag <= 1'b0;
			q.capFlag <= 1'b0;
			q.ovfEn   <= 1'b0;
			q.capEn   <= 1'b0;
			q.down    <= 1'b0;
			q.rdData  <= CTRL_RESET;
		end else begin
			q <= d;
		end
	end
endmodule : tc_timer
`default_nettype wire

// file: inc/tc_pkg.sv
`default_nettype none
package tc_pkg;
	// byte locations on the cpu side
	typedef logic [3:0] tc_io_addr_type;
	localparam tc_io_addr_type IO_CNT_LO  = 4'h0;
	localparam tc_io_addr_type IO_CNT_HI  = 4'h1;
	localparam tc_io_addr_type IO_CAP_LO  = 4'h2;
	localparam tc_io_addr_type IO_CAP_HI  = 4'h3;
	localparam tc_io_addr_type IO_CMP_LO  = 4'h4;
	localparam tc_io_addr_type IO_CMP_HI  = 4'h5;
	localparam tc_io_addr_type IO_CTRL_A  = 4'h6;
	localparam tc_io_addr_type IO_CTRL_B  = 4'h7;
	localparam tc_io_addr_type IO_FLAGS   = 4'h8;
	localparam tc_io_addr_type IO_MASK    = 4'h9;
	localparam tc_io_addr_type IO_COMP    = 4'hA;
	// field positions
	localparam int CTRLB_FILT   = 7;
	localparam int CTRLB_EDGE   = 6;
	localparam int CTRLB_WGM_HI = 3;
	localparam int CTRLB_CS     = 0;
	localparam int CTRLA_WGM_LO = 0;
	localparam int FLAG_OVF     = 0;
	localparam int FLAG_CAP     = 5;
	localparam int COMP_CAPSEL  = 2;
	// reset values
	localparam logic [7:0]  CTRL_RESET  = 8'h00;
	localparam logic [15:0] WORD_RESET  = 16'h0000;
	// fixed count limits
	localparam logic [15:0] TOP_MAX = 16'hFFFF;
	localparam logic [15:0] TOP_8   = 16'h00FF;
	localparam logic [15:0] TOP_9   = 16'h01FF;
	localparam logic [15:0] TOP_10  = 16'h03FF;
	// noise filter sample count
	localparam int FILTER_LEN = 4;
	// controller registers on apb
	localparam logic [11:0] APB_CMD    = 12'h000;
	localparam logic [11:0] APB_STATUS = 12'h004;
	localparam logic [11:0] APB_ACK    = 12'h008;
	localparam int CMD_ADDR_LSB = 8;
	localparam int CMD_WR_BIT   = 16;
	localparam int STAT_DATA_LSB = 8;
	localparam int STAT_OVF_IRQ = 16;
	localparam int STAT_CAP_IRQ = 17;

	typedef enum logic [2:0] {TS_MAX, TS_8, TS_9, TS_10, TS_CMP, TS_CAP} tc_top_type;
	typedef enum logic [1:0] {OV_MAX, OV_TOP, OV_BOTTOM} tc_ovf_type;
	typedef struct packed {
		tc_top_type topSel;
		logic       dual;
		tc_ovf_type ovfPt;
	} tc_mode_type;

	function automatic tc_mode_type tc_decode_mode(input logic [3:0] m);
		tc_mode_type r;
		r = '{TS_MAX, 1'b0, OV_MAX};
		unique case (m)
			4'h0, 4'hD: r = '{TS_MAX, 1'b0, OV_MAX};
			4'h1: r = '{TS_8, 1'b1, OV_BOTTOM};
			4'h2: r = '{TS_9, 1'b1, OV_BOTTOM};
			4'h3: r = '{TS_10, 1'b1, OV_BOTTOM};
			4'h4: r = '{TS_CMP, 1'b0, OV_MAX};
			4'h5: r = '{TS_8, 1'b0, OV_TOP};
			4'h6: r = '{TS_9, 1'b0, OV_TOP};
			4'h7: r = '{TS_10, 1'b0, OV_TOP};
			4'h8, 4'hA: r = '{TS_CAP, 1'b1, OV_BOTTOM};
			4'h9, 4'hB: r = '{TS_CMP, 1'b1, OV_BOTTOM};
			4'hC: r = '{TS_CAP, 1'b0, OV_MAX};
			4'hE: r = '{TS_CAP, 1'b0, OV_TOP};
			4'hF: r = '{TS_CMP, 1'b0, OV_TOP};
		endcase
		return r;
	endfunction : tc_decode_mode
endpackage : tc_pkg
`default_nettype wire

// file: inc/tc_cpu_if.sv
`timescale 1ns/100ps
`default_nettype none
interface tc_cpu_if;
	import tc_pkg::*;
	tc_io_addr_type ioAddr;
	logic           ioRd;
	logic           ioWr;
	logic [7:0]     ioWrData;
	logic [7:0]     ioRdData;
	logic           ovfIrq;
	logic           capIrq;
	logic           ovfAck;
	logic           capAck;

	modport dev (
		input  ioAddr, ioRd, ioWr, ioWrData, ovfAck, capAck,
		output ioRdData, ovfIrq, capIrq
	);
	modport cpu (
		output ioAddr, ioRd, ioWr, ioWrData, ovfAck, capAck,
		input  ioRdData, ovfIrq, capIrq
	);
endinterface : tc_cpu_if
`default_nettype wire

// file: hw/tc_capture_filter.sv
`timescale 1ns/100ps
`default_nettype none
module tc_capture_filter import tc_pkg::*; (
	input  wire logic clk_sys,
	input  wire logic rst_b,
	input  wire logic rawIn,
	input  wire logic filterEn,
	input  wire logic risingEdge,
	output logic      edgeSeen
);
	typedef struct packed {
		logic [1:0]            sync;
		logic [FILTER_LEN-2:0] hist;
		logic                  filt;
		logic                  prev;
	} tc_filter_state_type;

	tc_filter_state_type q;
	tc_filter_state_type d;
	logic [FILTER_LEN-1:0] samples;
	logic                  level;

	always_comb begin
		d = q;
		d.sync = {q.sync[0], rawIn};
		samples = {q.hist, q.sync[1]};
		d.hist = samples[FILTER_LEN-2:0];
		// four agreeing samples, taken every system clock, move the output
		if (&samples) begin
			d.filt = 1'b1;
		end else if (~|samples) begin
			d.filt = 1'b0;
		end
		level = filterEn ? q.filt : q.sync[1];
		d.prev = level;
		edgeSeen = (level != q.prev) && (level == risingEdge);
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end
endmodule : tc_capture_filter
`default_nettype wire

// file: hw/tc_host.sv
`timescale 1ns/100ps
`default_nettype none
module tc_host import tc_pkg::*; (
	input  wire logic        clk_sys,
	input  wire logic        rst_b,
	input  wire logic [11:0] paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	tc_cpu_if.cpu            cpu
);
	typedef enum logic [1:0] {ST_IDLE, ST_ISSUE, ST_WAIT} tc_host_st_type;
	typedef struct packed {
		tc_host_st_type st;
		tc_io_addr_type addr;
		logic [7:0]     wdata;
		logic           write;
		logic [7:0]     rdByte;
		logic [31:0]    prdata;
		logic           ackOvf;
		logic           ackCap;
	} tc_host_state_type;

	tc_host_state_type q;
	tc_host_state_type d;
	logic              access;
	logic              mapped;

	always_comb begin
		d = q;
		d.ackOvf = 1'b0;
		d.ackCap = 1'b0;
		access = psel && penable;
		mapped = (paddr == APB_CMD) || (paddr == APB_STATUS) || (paddr == APB_ACK);
		// read data is prepared in the setup cycle and held through access
		if (psel && !penable) begin
			d.prdata = '0;
			if (paddr == APB_STATUS) begin
				d.prdata[0] = (q.st != ST_IDLE);
				d.prdata[STAT_DATA_LSB+7:STAT_DATA_LSB] = q.rdByte;
				d.prdata[STAT_OVF_IRQ] = cpu.ovfIrq;
				d.prdata[STAT_CAP_IRQ] = cpu.capIrq;
			end
		end
		unique case (q.st)
			ST_IDLE: begin
				// a command while busy is dropped; software polls busy first
				if (access && pwrite && (paddr == APB_CMD)) begin
					d.st = ST_ISSUE;
					d.wdata = pwdata[7:0];
					d.addr = pwdata[CMD_ADDR_LSB+3:CMD_ADDR_LSB];
					d.write = pwdata[CMD_WR_BIT];
				end
			end
			ST_ISSUE: d.st = q.write ? ST_IDLE : ST_WAIT;
			ST_WAIT: begin
				d.rdByte = cpu.ioRdData;
				d.st = ST_IDLE;
			end
		endcase
		if (access && pwrite && (paddr == APB_ACK)) begin
			d.ackOvf = pwdata[0];
			d.ackCap = pwdata[1];
		end
		pready = access;
		pslverr = access && !mapped;
	end

	// each command is one byte access, so the ordering of high and low
	// bytes and keeping sequences atomic stays with software
	assign cpu.ioRd = (q.st == ST_ISSUE) && !q.write;
	assign cpu.ioWr = (q.st == ST_ISSUE) && q.write;
	assign cpu.ioAddr = q.addr;
	assign cpu.ioWrData = q.wdata;
	assign cpu.ovfAck = q.ackOvf;
	assign cpu.capAck = q.ackCap;
	assign prdata = q.prdata;

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			q <= '{ST_IDLE, IO_CNT_LO, 8'h00, 1'b0, 8'h00, 32'h00000000, 1'b0, 1'b0};
		end else begin
			q <= d;
		end
	end
endmodule : tc_host
`default_nettype wire

// file: tb/tc_chk.sv
`timescale 1ns/100ps
`default_nettype none
module tc_chk import tc_pkg::*; (
	input wire logic           clk_sys,
	input wire logic           rst_b,
	input wire tc_io_addr_type ioAddr,
	input wire logic           ioRd,
	input wire logic           ioWr,
	input wire logic [7:0]     ioWrData,
	input wire logic [7:0]     ioRdData,
	input wire logic           ovfIrq,
	input wire logic           capIrq,
	input wire logic           ovfAck,
	input wire logic           capAck
);
	logic [7:0] latch_q;
	logic [7:0] ctrlB_q;
	logic       latchOk_q;
	logic       ovfEn_q;
	logic       capEn_q;
	logic       hiWr;
	logic       loRd;
	assign hiWr = ioWr && (ioAddr == IO_CNT_HI || ioAddr == IO_CAP_HI || ioAddr == IO_CMP_HI);
	assign loRd = ioRd && (ioAddr == IO_CNT_LO || ioAddr == IO_CAP_LO);
	// the latch resets to zero, so its content is known until a low read reloads it
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			latch_q <= 8'h00;
			latchOk_q <= 1'b1;
			ctrlB_q <= CTRL_RESET;
			ovfEn_q <= 1'b0;
			capEn_q <= 1'b0;
		end else begin
			if (hiWr) latch_q <= ioWrData;
			if (hiWr || loRd) latchOk_q <= hiWr;
			if (ioWr && ioAddr == IO_CTRL_B) ctrlB_q <= ioWrData;
			if (ioWr && ioAddr == IO_MASK) ovfEn_q <= ioWrData[FLAG_OVF];
			if (ioWr && ioAddr == IO_MASK) capEn_q <= ioWrData[FLAG_CAP];
		end
	end
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	a_strobe_clash: assert property (!(ioRd && ioWr)) else $error("read and write together");
	a_read_single: assert property (ioRd |=> !ioRd) else $error("read strobe too long");
	a_ack_single: assert property ((ovfAck || capAck) |=> !(ovfAck || capAck))
		else $error("ack pulse too long");
	a_rddata_hold: assert property ((ioRdData != $past(ioRdData)) |-> $past(ioRd))
		else $error("read data moved without read");
	a_latch_read: assert property ((ioRd && latchOk_q && (ioAddr == IO_CNT_HI ||
		ioAddr == IO_CAP_HI)) |=> ioRdData == latch_q) else $error("high byte not latch");
	a_ctrlb_read: assert property ((ioRd && ioAddr == IO_CTRL_B) |=>
		ioRdData == ctrlB_q) else $error("control b readback");
	a_unmapped_zero: assert property ((ioRd && ioAddr > IO_COMP) |=> ioRdData == 8'h00)
		else $error("unmapped read not zero");
	a_ovf_gate: assert property (ovfIrq |-> ovfEn_q) else $error("overflow irq unmasked");
	a_cap_gate: assert property (capIrq |-> capEn_q) else $error("capture irq unmasked");
	c_count_write: cover property (ioWr && ioAddr == IO_CNT_LO);
	c_cap_irq: cover property ($rose(capIrq));
	c_ovf_irq: cover property ($rose(ovfIrq));
	c_cap_ack: cover property (capAck);
endmodule : tc_chk
`default_nettype wire

// file: tb/timer16_counter_input_capture_test.sv
`timescale 1ns/100ps
`default_nettype none
module timer16_counter_input_capture_test import tc_pkg::*; ;
	logic        clk_sys = 1'b0, rst_b = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, atBottom;
	logic [31:0] pwdata = 32'h00000000, prdata, junk, seed = 32'h0000002E;
	logic [7:0]  clockTicks = 8'h00, b;
	logic        capturePinIn = 1'b0, portDriveEn = 1'b0, portDriveValue = 1'b0;
	logic        comparatorOutput = 1'b0;
	logic        timerTick, atTop, pErr;
	logic [15:0] w, c;
	int          num_errors = 0, n_checks = 0, cycles = 0;
	// the dual slope case turns at 00FF and runs all the way down to flag at bottom
	logic [3:0]  tMode [6] = '{4'h0, 4'h5, 4'h6, 4'h4, 4'h1, 4'h0};
	logic [2:0]  tCs [6] = '{3'h2, 3'h2, 3'h2, 3'h2, 3'h2, 3'h0};
	logic [15:0] tStart [6] = '{16'hFFFD, 16'h00FE, 16'h01FE, 16'h000E, 16'h00FE, 16'h1234};
	logic [15:0] tExp [6] = '{16'h0001, 16'h0000, 16'h0001, 16'h0000, 16'h0001, 16'h1234};
	logic        tOvf [6] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
	int          tN [6] = '{4, 2, 3, 3, 257, 5};
	tc_cpu_if cpuBus ();
	tc_host tc_host_inst (.clk_sys(clk_sys), .rst_b(rst_b), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .cpu(cpuBus));
	tc_timer tc_timer_inst (.clk_sys(clk_sys), .rst_b(rst_b), .cpu(cpuBus),
		.clockTicks(clockTicks), .capturePinIn(capturePinIn), .portDriveEn(portDriveEn),
		.portDriveValue(portDriveValue), .comparatorOutput(comparatorOutput),
		.timerTick(timerTick), .atTop(atTop), .atBottom(atBottom));
	tc_chk tc_chk_inst (.clk_sys(clk_sys), .rst_b(rst_b), .ioAddr(cpuBus.ioAddr),
		.ioRd(cpuBus.ioRd), .ioWr(cpuBus.ioWr), .ioWrData(cpuBus.ioWrData),
		.ioRdData(cpuBus.ioRdData), .ovfIrq(cpuBus.ovfIrq), .capIrq(cpuBus.capIrq),
		.ovfAck(cpuBus.ovfAck), .capAck(cpuBus.capAck));
	always #5 clk_sys = ~clk_sys;
	task complete_run();
		$display("checks %0d mismatches %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : complete_run
	// generous ceiling: a full run needs under two thousand cycles
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 30000) begin
			num_errors++;
			complete_run();
		end
	end
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : xs
	task chk(input string what, input logic [15:0] e, input logic [15:0] g);
		n_checks++;
		if (g !== e) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", what, e, g);
		end
	endtask : chk
	task chkb(input string what, input logic e, input logic g);
		chk(what, {15'h0000, e}, {15'h0000, g});
	endtask : chkb
	task done(input string what);
		$display("test %s done", what);
	endtask : done
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys) penable <= 1'b1;
		do @(posedge clk_sys); while (pready !== 1'b1);
		r = prdata;
		pErr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// one byte access on the cpu bus, then poll until the host is idle again
	task io(input logic wr, input tc_io_addr_type a, input logic [7:0] d, output logic [7:0] r);
		logic [31:0] s;
		apb(1'b1, APB_CMD, {15'h0000, wr, 4'h0, a, d}, s);
		do apb(1'b0, APB_STATUS, 32'h00000000, s); while (s[0] !== 1'b0);
		r = s[STAT_DATA_LSB +: 8];
	endtask : io
	task wr(input tc_io_addr_type a, input logic [7:0] d);
		logic [7:0] t;
		io(1'b1, a, d, t);
	endtask : wr
	task rd(input tc_io_addr_type a, output logic [7:0] r);
		io(1'b0, a, 8'h00, r);
	endtask : rd
	task wr16(input tc_io_addr_type a, input logic [15:0] v);
		wr(a + 4'h1, v[15:8]);
		wr(a, v[7:0]);
	endtask : wr16
	task rd16(input tc_io_addr_type a, output logic [15:0] v);
		rd(a, v[7:0]);
		rd(a + 4'h1, v[15:8]);
	endtask : rd16
	task newc();
		junk = xs();
		c = junk[15:0];
		wr16(IO_CNT_LO, c);
	endtask : newc
	task tick(input int n);
		repeat (n) begin
			junk = xs();
			@(posedge clk_sys) clockTicks <= junk[7:0] | 8'h04;
			@(posedge clk_sys) clockTicks <= junk[7:0] & 8'hFB;
		end
	endtask : tick
	// enough for the synchroniser plus the four filter cycles
	task settle();
		repeat (8) @(posedge clk_sys);
	endtask : settle
	task expcap(input logic e, input logic [15:0] v);
		rd(IO_FLAGS, b);
		chkb("capture flag", e, b[FLAG_CAP]);
		rd16(IO_CAP_LO, w);
		if (e) chk("capture", v, w);
		wr(IO_FLAGS, 8'h20);
		rd(IO_FLAGS, b);
		chkb("flag clear", 1'b0, b[FLAG_CAP]);
	endtask : expcap
	initial begin
		repeat (12) @(posedge clk_sys);
		rst_b <= 1'b1;
		rd(IO_CTRL_B, b);
		chk("control b", {8'h00, CTRL_RESET}, {8'h00, b});
		rd16(IO_CNT_LO, w);
		chk("count", WORD_RESET, w);
		done("reset");
		for (int i = 0; i < 6; i++) begin
			junk = xs();
			c = (i == 0) ? 16'h0000 : (i == 1) ? 16'hFFFF : junk[15:0];
			wr16(IO_CNT_LO, c);
			rd16(IO_CNT_LO, w);
			chk("count", c, w);
		end
		wr(IO_CMP_HI, 8'hA5);
		rd(IO_CAP_HI, b);
		chk("latch", 16'h00A5, {8'h00, b});
		wr(IO_CNT_LO, 8'h3C);
		rd16(IO_CNT_LO, w);
		chk("count", 16'hA53C, w);
		rd(4'hB, b);
		chk("unmapped", 16'h0000, {8'h00, b});
		apb(1'b0, 12'h00C, 32'h00000000, junk);
		chkb("slave error", 1'b1, pErr);
		chk("unmapped apb", 16'h0000, junk[15:0]);
		apb(1'b0, APB_STATUS, 32'h00000000, junk);
		chkb("slave error", 1'b0, pErr);
		done("latch");
		wr16(IO_CMP_LO, 16'h0010);
		wr(IO_MASK, 8'h01);
		for (int i = 0; i < 6; i++) begin
			wr(IO_CTRL_A, {6'h00, tMode[i][1:0]});
			wr(IO_CTRL_B, {3'h0, tMode[i][3:2], tCs[i]});
			wr16(IO_CNT_LO, tStart[i]);
			apb(1'b1, APB_ACK, 32'h00000001, junk);
			tick(tN[i]);
			rd16(IO_CNT_LO, w);
			chk("count", tExp[i], w);
			chkb("bottom", tExp[i] == 16'h0000, atBottom);
			apb(1'b0, APB_STATUS, 32'h00000000, junk);
			chkb("overflow irq", tOvf[i], junk[STAT_OVF_IRQ]);
		end
		// stopped at the fixed limit: tick must stay low though every enable is high
		wr(IO_CTRL_A, 8'h01);
		wr(IO_CTRL_B, 8'h08);
		wr16(IO_CNT_LO, TOP_8);
		@(posedge clk_sys) clockTicks <= 8'hFF;
		@(posedge clk_sys);
		chkb("tick stopped", 1'b0, timerTick);
		chkb("top", 1'b1, atTop);
		wr(IO_CTRL_B, 8'h0A);
		chkb("tick running", 1'b1, timerTick);
		@(posedge clk_sys) clockTicks <= 8'h00;
		wr(IO_CTRL_A, 8'h00);
		done("count");
		wr(IO_CTRL_B, 8'h40);
		newc();
		@(posedge clk_sys) capturePinIn <= 1'b1;
		settle();
		expcap(1'b1, c);
		@(posedge clk_sys) capturePinIn <= 1'b0;
		settle();
		expcap(1'b0, c);
		wr(IO_CTRL_B, 8'h00);
		@(posedge clk_sys) portDriveEn <= 1'b1;
		for (int i = 0; i < 2; i++) begin
			newc();
			@(posedge clk_sys) portDriveValue <= 1'b1;
			settle();
			@(posedge clk_sys) portDriveValue <= 1'b0;
			settle();
		end
		expcap(1'b1, c);
		@(posedge clk_sys) portDriveEn <= 1'b0;
		wr(IO_COMP, 8'h04);
		wr(IO_CTRL_B, 8'h40);
		wr(IO_FLAGS, 8'h20);
		newc();
		@(posedge clk_sys) capturePinIn <= 1'b1;
		settle();
		expcap(1'b0, c);
		@(posedge clk_sys) comparatorOutput <= 1'b1;
		settle();
		expcap(1'b1, c);
		done("trigger");
		wr(IO_COMP, 8'h00);
		wr(IO_CTRL_B, 8'hC0);
		@(posedge clk_sys) capturePinIn <= 1'b0;
		settle();
		wr(IO_FLAGS, 8'h20);
		newc();
		@(posedge clk_sys) capturePinIn <= 1'b1;
		repeat (3) @(posedge clk_sys);
		capturePinIn <= 1'b0;
		settle();
		expcap(1'b0, c);
		wr(IO_MASK, 8'h21);
		@(posedge clk_sys) capturePinIn <= 1'b1;
		settle();
		apb(1'b0, APB_STATUS, 32'h00000000, junk);
		chkb("capture irq", 1'b1, junk[STAT_CAP_IRQ]);
		apb(1'b1, APB_ACK, 32'h00000002, junk);
		apb(1'b0, APB_STATUS, 32'h00000000, junk);
		chkb("capture irq", 1'b0, junk[STAT_CAP_IRQ]);
		rd16(IO_CAP_LO, w);
		chk("capture", c, w);
		done("filter");
		wr16(IO_CAP_LO, ~c);
		rd16(IO_CAP_LO, w);
		chk("capture kept", c, w);
		wr(IO_CTRL_B, 8'h58);
		wr16(IO_CAP_LO, ~c);
		rd16(IO_CAP_LO, w);
		chk("capture limit", ~c, w);
		wr(IO_FLAGS, 8'h20);
		@(posedge clk_sys) capturePinIn <= 1'b0;
		settle();
		@(posedge clk_sys) capturePinIn <= 1'b1;
		settle();
		expcap(1'b0, c);
		done("limit");
		complete_run();
	end
endmodule : timer16_counter_input_capture_test
`default_nettype wire
